// ==== uehr_pkg.sv ====
package uehr_pkg;

	// CPU-side addresses of the shared register block
	localparam logic [7:0] CPU_RXBUF_ADDR  = 8'h20;
	localparam logic [7:0] CPU_TXHOLD_ADDR = 8'h21;
	localparam logic [7:0] CPU_LCR_ADDR    = 8'h22;
	localparam logic [7:0] CPU_MCR_ADDR    = 8'h23;
	localparam logic [7:0] CPU_DIVLO_ADDR  = 8'h24;
	localparam logic [7:0] CPU_DIVHI_ADDR  = 8'h25;
	localparam logic [7:0] CPU_SCR_ADDR    = 8'h26;
	localparam logic [7:0] CPU_HHR_ADDR    = 8'h2f;
	localparam logic [7:0] CPU_LSR_ADDR    = 8'h30;
	localparam logic [7:0] CPU_MSR_ADDR    = 8'h31;
	localparam logic [7:0] CPU_HCR_ADDR    = 8'h32;

	// Host-side addresses
	localparam logic [3:0] HOST_DATA_ADDR = 4'h0;
	localparam logic [3:0] HOST_IER_ADDR  = 4'h1;
	localparam logic [3:0] HOST_LCR_ADDR  = 4'h3;
	localparam logic [3:0] HOST_MCR_ADDR  = 4'h4;
	localparam logic [3:0] HOST_LSR_ADDR  = 4'h5;
	localparam logic [3:0] HOST_MSR_ADDR  = 4'h6;
	localparam logic [3:0] HOST_SCR_ADDR  = 4'h7;
	localparam logic [3:0] HOST_HHR_ADDR  = 4'hf;

	// Host control bit positions
	localparam int HCR_IRQ_EN    = 0;
	localparam int HCR_MODE_SEL  = 1;
	localparam int HCR_HOST_EN   = 2;
	localparam int HCR_DIV_FLAG  = 4;
	localparam int HCR_LCR_FLAG  = 5;
	localparam int HCR_MCR_FLAG  = 6;
	localparam int HCR_TX_FLAG   = 7;
	localparam logic [7:0] HCR_FIXED_ONES = 8'h08;

	// Line control bit positions
	localparam int LCR_STB   = 2;
	localparam int LCR_PEN   = 3;
	localparam int LCR_EPS   = 4;
	localparam int LCR_STICK = 5;
	localparam int LCR_BREAK = 6;

	// Modem control / status bit positions
	localparam int MCR_DTR  = 0;
	localparam int MCR_RTS  = 1;
	localparam int MCR_OUT1 = 2;
	localparam int MCR_OUT2 = 3;
	localparam int MCR_LOOP = 4;

	// Line status bit positions
	localparam int LSR_DR   = 0;
	localparam int LSR_TX_HOLDING_EMPTY = 5;
	localparam int LSR_TEMT = 6;
	localparam logic [6:0] LSR_ERR_MASK = 7'h1e;

	// Reset values
	localparam logic [7:0] HCR_RST  = 8'h00;
	localparam logic [7:0] HHR_RST  = 8'h00;
	localparam logic [6:0] LSR_RST  = 7'h00;
	localparam logic [7:0] MSR_RST  = 8'h00;
	localparam logic [4:0] MCR_RST  = 5'h00;
	localparam logic [7:0] BUF_RST  = 8'h00;

	// Character format constants
	localparam logic [3:0] MIN_DATA_BITS   = 4'h5;
	localparam logic [2:0] ONE_STOP_HALVES = 3'h2;
	localparam logic [2:0] ONE5_STOP_HALVES = 3'h3;
	localparam logic [2:0] TWO_STOP_HALVES = 3'h4;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} uehr_host_req_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} uehr_cpu_req_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic [2:0] stop_halves;
		logic       parity_on;
		logic       parity_stick;
		logic       even_parity_sel;
		logic       break_on;
	} uehr_line_fmt_t;

endpackage : uehr_pkg

// ==== uehr_regs.sv ====
`timescale 1ns/10ps
module uehr_regs
	import uehr_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire uehr_host_req_t host_req,
	output logic [7:0]          host_rdata,
	input  wire uehr_cpu_req_t  cpu_req,
	output logic [7:0]          cpu_rdata,
	input  wire logic           rxd_in,
	output logic                rxd_out,
	input  wire logic [7:0]     tx_char,
	output logic                tx_parity_bit,
	output uehr_line_fmt_t      line_fmt,
	output logic [15:0]         baud_divisor,
	output logic                host_irq_out,
	output logic                host_irq_oe,
	output logic                cpu_irq_line_three
);

	function automatic logic uart_hit(input uehr_host_req_t r, input logic [3:0] a);
		uart_hit = (r.addr == a);
	endfunction : uart_hit

	function automatic logic [7:0] len_mask(input logic [1:0] sel);
		unique case (sel)
			2'b00: len_mask = 8'h1f;
			2'b01: len_mask = 8'h3f;
			2'b10: len_mask = 8'h7f;
			2'b11: len_mask = 8'hff;
		endcase
	endfunction : len_mask

	logic [6:0] lcr_q;
	logic       divisor_access_bit_q;
	logic [4:0] mcr_q;
	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [7:0] scr_q;
	logic [7:0] rxbuf_q;
	logic [7:0] txhold_q;
	logic [6:0] lsr_q;
	logic [6:0] lsr_d;
	logic [7:0] msr_q;
	logic [7:0] msr_d;
	logic [7:0] hcr_q;
	logic [7:0] hcr_d;
	logic [7:0] hhr_q;
	logic [7:0] hhr_d;
	logic [7:0] cpu_rd_d;
	logic [7:0] host_rd_d;
	logic [7:0] msr_view;

	logic host_on, uart_mode, hw, hr, cw, loop_on;
	logic h_thr_wr, h_rbr_rd, h_dlo_wr, h_dhi_wr, h_lcr_wr, h_mcr_wr;
	logic h_msr_wr, h_scr_wr, h_hhr_wr, h_lsr_rd, h_msr_rd;

	assign host_on   = hcr_q[HCR_HOST_EN];
	assign uart_mode = host_on & hcr_q[HCR_MODE_SEL];
	assign hw        = host_req.wr & uart_mode;
	assign hr        = host_req.rd & uart_mode;
	assign loop_on   = mcr_q[MCR_LOOP];
	assign cw        = cpu_req.wr;

	// Low addresses steer by the host-only latch
	assign h_thr_wr = hw & uart_hit(host_req, HOST_DATA_ADDR) & ~divisor_access_bit_q;
	assign h_rbr_rd = hr & uart_hit(host_req, HOST_DATA_ADDR) & ~divisor_access_bit_q;
	assign h_dlo_wr = hw & uart_hit(host_req, HOST_DATA_ADDR) & divisor_access_bit_q;
	assign h_dhi_wr = hw & uart_hit(host_req, HOST_IER_ADDR) & divisor_access_bit_q;
	assign h_lcr_wr = hw & uart_hit(host_req, HOST_LCR_ADDR);
	assign h_mcr_wr = hw & uart_hit(host_req, HOST_MCR_ADDR);
	assign h_msr_wr = hw & uart_hit(host_req, HOST_MSR_ADDR);
	assign h_scr_wr = hw & uart_hit(host_req, HOST_SCR_ADDR);
	assign h_lsr_rd = hr & uart_hit(host_req, HOST_LSR_ADDR);
	assign h_msr_rd = hr & uart_hit(host_req, HOST_MSR_ADDR);
	assign h_hhr_wr = host_req.wr & host_on & ~hcr_q[HCR_MODE_SEL]
		& uart_hit(host_req, HOST_HHR_ADDR);

	// Line control: no reset on the shared byte
	always_ff @(posedge clk)
	begin
		if (h_lcr_wr)
			lcr_q <= host_req.wdata[6:0];
		else if (cw && cpu_req.addr == CPU_LCR_ADDR)
			lcr_q <= cpu_req.wdata[6:0];
	end

	// Address-extension latch, host only
	always_ff @(posedge clk)
	begin
		if (srst)
			divisor_access_bit_q <= 1'b0;
		else if (h_lcr_wr)
			divisor_access_bit_q <= host_req.wdata[7];
	end

	// Divisor and scratch bytes keep power-up contents through reset
	always_ff @(posedge clk)
	begin
		if (h_dlo_wr)
			div_lo_q <= host_req.wdata;
		else if (cw && cpu_req.addr == CPU_DIVLO_ADDR)
			div_lo_q <= cpu_req.wdata;
		if (h_dhi_wr)
			div_hi_q <= host_req.wdata;
		else if (cw && cpu_req.addr == CPU_DIVHI_ADDR)
			div_hi_q <= cpu_req.wdata;
		if (h_scr_wr)
			scr_q <= host_req.wdata;
		else if (cw && cpu_req.addr == CPU_SCR_ADDR)
			scr_q <= cpu_req.wdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			mcr_q <= MCR_RST;
		else if (h_mcr_wr)
			mcr_q <= host_req.wdata[4:0];
		else if (cw && cpu_req.addr == CPU_MCR_ADDR)
			mcr_q <= cpu_req.wdata[4:0];
	end

	// Data buffers; loop mode copies the transmit byte across
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rxbuf_q  <= BUF_RST;
			txhold_q <= BUF_RST;
		end
		else
		begin
			if (h_thr_wr)
				txhold_q <= host_req.wdata;
			if (h_thr_wr && loop_on)
				rxbuf_q <= host_req.wdata;
			else if (cw && cpu_req.addr == CPU_RXBUF_ADDR)
				rxbuf_q <= cpu_req.wdata;
		end
	end

	// Line status: set wins over host-side clears
	always_comb
	begin
		logic [6:0] set_v;
		logic [6:0] clr_v;
		set_v = '0;
		clr_v = '0;
		if (cw && cpu_req.addr == CPU_LSR_ADDR)
			set_v = ~cpu_req.wdata[6:0];
		if (h_thr_wr && loop_on)
			set_v[LSR_DR] = 1'b1;
		if (h_rbr_rd)
			clr_v[LSR_DR] = 1'b1;
		if (h_lsr_rd)
			clr_v = clr_v | LSR_ERR_MASK;
		if (h_thr_wr)
		begin
			clr_v[LSR_TX_HOLDING_EMPTY] = 1'b1;
			clr_v[LSR_TEMT] = 1'b1;
		end
		lsr_d = set_v | (lsr_q & ~clr_v);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			lsr_q <= LSR_RST;
		else
			lsr_q <= lsr_d;
	end

	// Modem status: deltas sticky, levels plain storage
	always_comb
	begin
		msr_d = msr_q;
		if (h_msr_rd)
			msr_d[3:0] = 4'h0;
		if (cw && cpu_req.addr == CPU_MSR_ADDR)
		begin
			msr_d[3:0] = msr_d[3:0] | ~cpu_req.wdata[3:0];
			msr_d[7:4] = cpu_req.wdata[7:4];
		end
		else if (h_msr_wr)
			msr_d[7:4] = host_req.wdata[7:4];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			msr_q <= MSR_RST;
		else
			msr_q <= msr_d;
	end

	// Host control: CPU owns bits 2:0, flags set by host writes
	always_comb
	begin
		logic [7:0] set_v;
		set_v = '0;
		set_v[HCR_DIV_FLAG] = h_dlo_wr | h_dhi_wr;
		set_v[HCR_LCR_FLAG] = h_lcr_wr;
		set_v[HCR_MCR_FLAG] = h_mcr_wr;
		set_v[HCR_TX_FLAG]  = h_thr_wr;
		hcr_d = hcr_q;
		if (cw && cpu_req.addr == CPU_HCR_ADDR)
		begin
			hcr_d[2:0] = cpu_req.wdata[2:0];
			hcr_d[7:4] = hcr_q[7:4] & cpu_req.wdata[7:4];
		end
		hcr_d[7:4] = hcr_d[7:4] | set_v[7:4];
		hcr_d[3]   = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			hcr_q <= HCR_RST;
		else
			hcr_q <= hcr_d;
	end

	// Handshake: split write ownership per bit
	always_comb
	begin
		logic cpu_hit;
		cpu_hit = cw && cpu_req.addr == CPU_HHR_ADDR;
		hhr_d = hhr_q;
		if (h_hhr_wr)
			hhr_d[1:0] = host_req.wdata[1:0];
		if (cpu_hit)
			hhr_d[3:2] = cpu_req.wdata[3:2];
		if (h_hhr_wr)
			hhr_d[5:4] = hhr_d[5:4] & host_req.wdata[5:4];
		if (cpu_hit)
			hhr_d[7:6] = hhr_d[7:6] & cpu_req.wdata[7:6];
		if (cpu_hit)
			hhr_d[5:4] = hhr_d[5:4] | ~cpu_req.wdata[5:4];
		if (h_hhr_wr)
			hhr_d[7:6] = hhr_d[7:6] | host_req.wdata[7:6];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			hhr_q <= HHR_RST;
		else
			hhr_q <= hhr_d;
	end

	// Loop mode status view
	always_comb
	begin
		msr_view = msr_q;
		if (loop_on)
			msr_view[7:4] = {mcr_q[MCR_OUT2], mcr_q[MCR_OUT1],
				mcr_q[MCR_DTR], mcr_q[MCR_RTS]};
	end

	always_comb
	begin
		host_rd_d = 8'h00;
		unique case (host_req.addr)
			HOST_DATA_ADDR: host_rd_d = divisor_access_bit_q ? div_lo_q : rxbuf_q;
			HOST_IER_ADDR:  host_rd_d = divisor_access_bit_q ? div_hi_q : 8'h00;
			HOST_LCR_ADDR:  host_rd_d = {divisor_access_bit_q, lcr_q};
			HOST_MCR_ADDR:  host_rd_d = {3'h0, mcr_q};
			HOST_LSR_ADDR:  host_rd_d = {1'b0, lsr_q};
			HOST_MSR_ADDR:  host_rd_d = msr_view;
			HOST_SCR_ADDR:  host_rd_d = scr_q;
			default:        host_rd_d = 8'h00;
		endcase
		if (!uart_mode)
			host_rd_d = (host_on && host_req.addr == HOST_HHR_ADDR) ? hhr_q : 8'h00;
	end

	always_comb
	begin
		unique case (cpu_req.addr)
			CPU_RXBUF_ADDR:  cpu_rd_d = rxbuf_q;
			CPU_TXHOLD_ADDR: cpu_rd_d = txhold_q;
			CPU_LCR_ADDR:    cpu_rd_d = {divisor_access_bit_q, lcr_q};
			CPU_MCR_ADDR:    cpu_rd_d = {3'h0, mcr_q};
			CPU_DIVLO_ADDR:  cpu_rd_d = div_lo_q;
			CPU_DIVHI_ADDR:  cpu_rd_d = div_hi_q;
			CPU_SCR_ADDR:    cpu_rd_d = scr_q;
			CPU_HHR_ADDR:    cpu_rd_d = hhr_q;
			CPU_LSR_ADDR:    cpu_rd_d = {1'b0, lsr_q};
			CPU_MSR_ADDR:    cpu_rd_d = msr_q;
			CPU_HCR_ADDR:    cpu_rd_d = hcr_q | HCR_FIXED_ONES;
			default:         cpu_rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			host_rdata <= 8'h00;
			cpu_rdata  <= 8'h00;
		end
		else
		begin
			if (host_req.rd)
				host_rdata <= host_rd_d;
			if (cpu_req.rd)
				cpu_rdata <= cpu_rd_d;
		end
	end

	// Interrupt lines
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			host_irq_out       <= 1'b0;
			host_irq_oe        <= 1'b0;
			cpu_irq_line_three <= 1'b0;
		end
		else
		begin
			host_irq_out <= |(hhr_q[1:0] & hhr_q[5:4]);
			host_irq_oe  <= mcr_q[MCR_OUT2];
			cpu_irq_line_three <= |(hhr_q[3:2] & hhr_q[7:6])
				| (hcr_q[HCR_IRQ_EN] & |hcr_q[7:4]);
		end
	end

	// Character format decode and line helpers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			line_fmt      <= '0;
			rxd_out       <= 1'b1;
			tx_parity_bit <= 1'b0;
			baud_divisor  <= 16'h0000;
		end
		else
		begin
			line_fmt.data_bits <= MIN_DATA_BITS + {2'b00, lcr_q[1:0]};
			if (!lcr_q[LCR_STB])
				line_fmt.stop_halves <= ONE_STOP_HALVES;
			else if (lcr_q[1:0] == 2'b00)
				line_fmt.stop_halves <= ONE5_STOP_HALVES;
			else
				line_fmt.stop_halves <= TWO_STOP_HALVES;
			line_fmt.parity_on       <= lcr_q[LCR_PEN];
			line_fmt.parity_stick    <= lcr_q[LCR_STICK];
			line_fmt.even_parity_sel <= lcr_q[LCR_EPS];
			line_fmt.break_on        <= lcr_q[LCR_BREAK];
			rxd_out <= rxd_in & ~lcr_q[LCR_BREAK];
			if (lcr_q[LCR_STICK])
				tx_parity_bit <= ~lcr_q[LCR_EPS];
			else
				tx_parity_bit <= ^(tx_char & len_mask(lcr_q[1:0])) ^ ~lcr_q[LCR_EPS];
			baud_divisor <= {div_hi_q, div_lo_q};
		end
	end

	a_lcr_flag_set: assert property (@(posedge clk) disable iff (srst)
		h_lcr_wr |=> hcr_q[HCR_LCR_FLAG])
		else $error("line control write flag not set");

	a_mcr_flag_set: assert property (@(posedge clk) disable iff (srst)
		h_mcr_wr |=> hcr_q[HCR_MCR_FLAG])
		else $error("modem control write flag not set");

	a_div_flag_set: assert property (@(posedge clk) disable iff (srst)
		(h_dlo_wr || h_dhi_wr) |=> hcr_q[HCR_DIV_FLAG])
		else $error("divisor write flag not set");

	a_dr_read_clear: assert property (@(posedge clk) disable iff (srst)
		(h_rbr_rd && !(cw && cpu_req.addr == CPU_LSR_ADDR)) |=> !lsr_q[LSR_DR])
		else $error("data ready not cleared by buffer read");

	a_lsr_err_clear: assert property (@(posedge clk) disable iff (srst)
		(h_lsr_rd && !(cw && cpu_req.addr == CPU_LSR_ADDR)) |=> (lsr_q[4:1] == 4'h0))
		else $error("line status errors not cleared by read");

	a_tx_holding_empty_temt_clear: assert property (@(posedge clk) disable iff (srst)
		(h_thr_wr && !(cw && cpu_req.addr == CPU_LSR_ADDR))
		|=> (!lsr_q[LSR_TX_HOLDING_EMPTY] && !lsr_q[LSR_TEMT]))
		else $error("transmit empty bits not cleared");

	a_lsr_set_wins: assert property (@(posedge clk) disable iff (srst)
		(cw && cpu_req.addr == CPU_LSR_ADDR && !cpu_req.wdata[LSR_DR])
		|=> lsr_q[LSR_DR])
		else $error("cpu set of data ready lost");

	a_msr_delta_clear: assert property (@(posedge clk) disable iff (srst)
		(h_msr_rd && !(cw && cpu_req.addr == CPU_MSR_ADDR)) |=> (msr_q[3:0] == 4'h0))
		else $error("modem deltas not cleared by read");

	a_loop_msr_map: assert property (@(posedge clk) disable iff (srst)
		(h_msr_rd && loop_on) |=> (host_rdata[7:4] == {$past(mcr_q[3]),
			$past(mcr_q[2]), $past(mcr_q[0]), $past(mcr_q[1])}))
		else $error("loop modem status mapping wrong");

	a_loop_copy: assert property (@(posedge clk) disable iff (srst)
		(h_thr_wr && loop_on) |=> (rxbuf_q == $past(host_req.wdata)))
		else $error("loop byte not in receive buffer");

	a_host_irq_out_gate: assert property (@(posedge clk) disable iff (srst)
		!mcr_q[MCR_OUT2] [*2] |-> !host_irq_oe)
		else $error("host interrupt driven while disabled");

	a_cf_host_set: assert property (@(posedge clk) disable iff (srst)
		(h_hhr_wr && host_req.wdata[7]) |=> hhr_q[7])
		else $error("controller flag not set by host");

	a_stop_count: assert property (@(posedge clk) disable iff (srst)
		(lcr_q[LCR_STB] && lcr_q[1:0] == 2'b00 && !h_lcr_wr
		&& !(cw && cpu_req.addr == CPU_LCR_ADDR)) |=> (line_fmt.stop_halves == 3'h3))
		else $error("stop count wrong for five bit characters");

endmodule : uehr_regs

// ==== uehr_host_model.sv ====
`timescale 1ns/10ps
module uehr_host_model
	import uehr_pkg::*;
(
	input  wire logic       clk,
	output uehr_host_req_t  host_req,
	input  wire logic [7:0] host_rdata
);
	initial host_req = '0;

	// One access, strobe held across exactly one rising edge
	task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		host_req <= '{rd: rd, wr: ~rd, addr: a, wdata: d};
		@(negedge clk);
		host_req <= '0;
	endtask : access
endmodule : uehr_host_model

// ==== tb.sv ====
`timescale 1ns/10ps
module tb
	import uehr_pkg::*;
;
	typedef struct packed {
		logic       src;
		logic [7:0] mask;
		logic [7:0] exp;
	} uehr_exp_t;

	logic           clk;
	logic           srst;
	logic           rxd_in;
	logic           rxd_out;
	logic           tx_parity_bit;
	logic           host_irq_out;
	logic           host_irq_oe;
	logic           cpu_irq_line_three;
	logic           h_pend;
	logic           c_pend;
	logic [7:0]     host_rdata;
	logic [7:0]     cpu_rdata;
	logic [7:0]     tx_char;
	logic [15:0]    baud_divisor;
	uehr_host_req_t host_req;
	uehr_cpu_req_t  cpu_req;
	uehr_line_fmt_t line_fmt;
	uehr_exp_t      exp_q[$];
	int             n_mismatch = 0;
	int             cmp_count = 0;
	int             seed = 97;

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	uehr_regs uehr_regs_inst (
		.clk(clk), .srst(srst), .host_req(host_req), .host_rdata(host_rdata),
		.cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .rxd_in(rxd_in), .rxd_out(rxd_out),
		.tx_char(tx_char), .tx_parity_bit(tx_parity_bit), .line_fmt(line_fmt),
		.baud_divisor(baud_divisor), .host_irq_out(host_irq_out),
		.host_irq_oe(host_irq_oe), .cpu_irq_line_three(cpu_irq_line_three)
	);

	uehr_host_model uehr_host_model_inst (
		.clk(clk), .host_req(host_req), .host_rdata(host_rdata)
	);

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle

	task automatic c_acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cpu_req <= '{rd: rd, wr: ~rd, addr: a, wdata: d};
		@(negedge clk);
		cpu_req <= '0;
	endtask : c_acc

	task automatic c_wr(input logic [7:0] a, input logic [7:0] d);
		c_acc(1'b0, a, d);
	endtask : c_wr

	task automatic c_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		exp_q.push_back('{src: 1'b0, mask: m, exp: e});
		c_acc(1'b1, a, 8'h00);
	endtask : c_rd

	task automatic h_wr(input logic [3:0] a, input logic [7:0] d);
		uehr_host_model_inst.access(1'b0, a, d);
	endtask : h_wr

	task automatic h_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		exp_q.push_back('{src: 1'b1, mask: m, exp: e});
		uehr_host_model_inst.access(1'b1, a, 8'h00);
	endtask : h_rd

	// Read data scoreboard
	always @(posedge clk)
	begin
		h_pend <= host_req.rd;
		c_pend <= cpu_req.rd;
	end

	always @(negedge clk)
	begin
		uehr_exp_t e;
		if (h_pend === 1'b1 || c_pend === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("read_queue", 16'h0001, 16'h0000);
			else
			begin
				e = exp_q.pop_front();
				if (e.src)
					check("host_rdata", {8'h00, host_rdata & e.mask}, {8'h00, e.exp & e.mask});
				else
					check("cpu_rdata", {8'h00, cpu_rdata & e.mask}, {8'h00, e.exp & e.mask});
			end
		end
	end

	initial
	begin
		#160000;
		n_mismatch++;
		final_report();
	end

	initial
	begin
		logic [7:0]     line_control;
		logic [7:0]     dm;
		logic [7:0]     d;
		logic           par;
		uehr_line_fmt_t ef;
		srst = 1'b1;
		cpu_req = '0;
		rxd_in = 1'b1;
		tx_char = 8'h00;
		settle(16);
		srst = 1'b0;
		// Reset values and unmapped address
		c_rd(CPU_HCR_ADDR, 8'h08);
		c_rd(CPU_HHR_ADDR, 8'h00);
		c_rd(CPU_LSR_ADDR, 8'h00);
		c_rd(CPU_MSR_ADDR, 8'h00);
		c_rd(CPU_MCR_ADDR, 8'h00);
		c_rd(8'h40, 8'h00);
		// Host port disabled
		h_wr(HOST_LCR_ADDR, 8'h03);
		c_rd(CPU_HCR_ADDR, 8'h08);
		c_wr(CPU_HCR_ADDR, 8'h06);
		c_rd(CPU_HCR_ADDR, 8'h0e);
		// Divisor access and flags
		h_wr(HOST_LCR_ADDR, 8'h83);
		c_rd(CPU_HCR_ADDR, 8'h2e);
		h_wr(HOST_DATA_ADDR, 8'h34);
		h_wr(HOST_IER_ADDR, 8'h12);
		settle(2);
		check("baud_divisor", baud_divisor, 16'h1234);
		c_rd(CPU_HCR_ADDR, 8'h3e);
		c_wr(CPU_LCR_ADDR, 8'h03);
		h_rd(HOST_DATA_ADDR, 8'h34);
		c_rd(CPU_DIVHI_ADDR, 8'h12);
		h_wr(HOST_SCR_ADDR, 8'ha5);
		c_rd(CPU_SCR_ADDR, 8'ha5);
		c_wr(CPU_HCR_ADDR, 8'hf6);
		c_rd(CPU_HCR_ADDR, 8'h3e);
		c_wr(CPU_HCR_ADDR, 8'h06);
		c_rd(CPU_HCR_ADDR, 8'h0e);
		// Set and clear in one cycle
		fork
			h_wr(HOST_MCR_ADDR, 8'h08);
			c_wr(CPU_HCR_ADDR, 8'h06);
		join
		c_rd(CPU_HCR_ADDR, 8'h4e);
		check("host_irq_oe", {15'h0, host_irq_oe}, 16'h0001);
		h_wr(HOST_MCR_ADDR, 8'h00);
		settle(2);
		check("host_irq_oe", {15'h0, host_irq_oe}, 16'h0000);
		// Every combination of line control bits 5:0; break bit random
		for (int i = 0; i < 64; i++)
		begin
			line_control = {1'b0, 1'($random(seed)), 6'(i)};
			rxd_in = 1'($random(seed));
			tx_char = 8'($random(seed));
			h_wr(HOST_LCR_ADDR, line_control);
			settle(3);
			ef.data_bits = MIN_DATA_BITS + {2'b00, line_control[1:0]};
			ef.stop_halves = !line_control[LCR_STB] ? ONE_STOP_HALVES :
				(line_control[1:0] == 2'b00 ? ONE5_STOP_HALVES : TWO_STOP_HALVES);
			ef.parity_on = line_control[LCR_PEN];
			ef.parity_stick = line_control[LCR_STICK];
			ef.even_parity_sel = line_control[LCR_EPS];
			ef.break_on = line_control[LCR_BREAK];
			check("line_fmt", {5'h00, line_fmt}, {5'h00, ef});
			check("rxd_out", {15'h0, rxd_out}, {15'h0, rxd_in & ~line_control[LCR_BREAK]});
			dm = 8'hff >> (2'd3 - line_control[1:0]);
			par = line_control[LCR_STICK] ? ~line_control[LCR_EPS] :
				(line_control[LCR_EPS] ? ^(tx_char & dm) : ~^(tx_char & dm));
			if (line_control[LCR_PEN])
				check("tx_parity_bit", {15'h0, tx_parity_bit}, {15'h0, par});
		end
		// Line status set and clear; the host never writes it
		c_wr(CPU_LSR_ADDR, 8'h80);
		c_rd(CPU_LSR_ADDR, 8'h7f);
		h_rd(HOST_LSR_ADDR, 8'h7f);
		c_rd(CPU_LSR_ADDR, 8'h61);
		h_rd(HOST_DATA_ADDR, 8'h00, 8'h00);
		c_rd(CPU_LSR_ADDR, 8'h60);
		// Loop mode
		d = 8'($random(seed));
		h_wr(HOST_MCR_ADDR, 8'h1b);
		h_wr(HOST_DATA_ADDR, d);
		c_rd(CPU_RXBUF_ADDR, d);
		c_rd(CPU_LSR_ADDR, 8'h01);
		c_rd(CPU_HCR_ADDR, 8'h80, 8'h80);
		c_wr(CPU_MSR_ADDR, 8'hf0);
		h_rd(HOST_MSR_ADDR, 8'hbf);
		c_rd(CPU_MSR_ADDR, 8'hf0);
		h_wr(HOST_MCR_ADDR, 8'h00);
		h_wr(HOST_MSR_ADDR, 8'h5a);
		c_rd(CPU_MSR_ADDR, 8'h50, 8'hf0);
		h_rd(HOST_MSR_ADDR, 8'h50, 8'hf0);
		// Handshake in general purpose mode
		c_wr(CPU_HCR_ADDR, 8'h04);
		h_wr(HOST_HHR_ADDR, 8'h03);
		settle(2);
		check("host_irq_out", {15'h0, host_irq_out}, 16'h0000);
		c_wr(CPU_HHR_ADDR, 8'h0c);
		c_rd(CPU_HHR_ADDR, 8'h3f);
		check("host_irq_out", {15'h0, host_irq_out}, 16'h0001);
		check("cpu_irq", {15'h0, cpu_irq_line_three}, 16'h0000);
		h_wr(HOST_HHR_ADDR, 8'hc3);
		h_rd(HOST_HHR_ADDR, 8'hcf);
		settle(1);
		check("host_irq_out", {15'h0, host_irq_out}, 16'h0000);
		check("cpu_irq", {15'h0, cpu_irq_line_three}, 16'h0001);
		c_wr(CPU_HHR_ADDR, 8'h30);
		c_rd(CPU_HHR_ADDR, 8'h03);
		check("cpu_irq", {15'h0, cpu_irq_line_three}, 16'h0000);
		settle(3);
		final_report();
	end
endmodule : tb
